// ===== src/sie_fp_single.sv
// sie_fp_single: double to single format packing for floating stores
// assumes the source already holds a single-representable value
`timescale 1ns/1ps
module sie_fp_single
   import sie_pkg::*;
(
   input  wire logic [63:0] dbl_in,
   output logic      [31:0] sgl_out
);
   // --------------------------------------------------------------
   // packing
   // --------------------------------------------------------------
   // exponent above the denormal threshold, or zero, keeps bits 0:1 and 5:34;
   // smaller nonzero exponents are denormalised by shifting the implied one in
   logic [10:0] exp_w;
   logic [5:0]  shamt_w;
   logic [31:0] frac_w;
   assign exp_w = dbl_in[62:52];
   always_comb begin
      shamt_w = 6'h00;
      frac_w  = 32'h0;
      if (exp_w > 11'h380 || exp_w == 11'h000) begin
         sgl_out = {dbl_in[63:62], dbl_in[58:29]};   // RULE10
      end else begin
         shamt_w = 6'(11'h381 - exp_w);
         // bit 31 holds the implied one, so the stored fraction starts one below it
         frac_w  = {1'b1, dbl_in[51:21]} >> shamt_w;
         sgl_out = {dbl_in[63], 8'h00, frac_w[30:8]};  // RULE11
      end
   end
endmodule // sie_fp_single

// ===== src/sie_pkg.sv
// sie_pkg: shared constants and carriers for the store instruction executor
// assumes a 64-bit big-endian-numbered instruction set, bit 0 is the msb
package sie_pkg;
   // ----------------------------------------------------------------
   // opcode encodings
   // ----------------------------------------------------------------
   localparam logic [5:0] SIE_OP_EXT     = 6'h1F;  // indexed group, primary 31
   localparam logic [5:0] SIE_OP_DWORD   = 6'h3E;  // dword store family, primary 62
   localparam logic [5:0] SIE_OP_STFD    = 6'h36;
   localparam logic [5:0] SIE_OP_STFDU   = 6'h37;
   localparam logic [5:0] SIE_OP_STFS    = 6'h34;
   localparam logic [5:0] SIE_OP_STFSU   = 6'h35;
   localparam logic [5:0] SIE_OP_STH     = 6'h2C;
   localparam logic [5:0] SIE_OP_STHU    = 6'h2D;
   localparam logic [1:0] SIE_DWSUB_PLAIN = 2'h0;  // dword sub-opcode, plain
   localparam logic [1:0] SIE_DWSUB_UPD   = 2'h1;  // dword sub-opcode, update
   localparam logic [9:0] SIE_XO_STDX    = 10'h095; // 149
   localparam logic [9:0] SIE_XO_STDUX   = 10'h0B5; // 181
   localparam logic [9:0] SIE_XO_STFDX   = 10'h2D7; // 727
   localparam logic [9:0] SIE_XO_STFDUX  = 10'h2F7; // 759
   localparam logic [9:0] SIE_XO_STFSX   = 10'h297; // 663
   localparam logic [9:0] SIE_XO_STFSUX  = 10'h2B7; // 695
   localparam logic [9:0] SIE_XO_STFIWX  = 10'h3D7; // 983
   localparam logic [9:0] SIE_XO_STHBRX  = 10'h396; // 918
   // ----------------------------------------------------------------
   // field positions (lsb-numbered, within the 32-bit word)
   // ----------------------------------------------------------------
   localparam int SIE_POS_OPC = 26;
   localparam int SIE_POS_SRC = 21;
   localparam int SIE_POS_BAS = 16;
   localparam int SIE_POS_IDX = 11;
   localparam int SIE_POS_XO  = 1;
   // ----------------------------------------------------------------
   // byte-enable masks for the access sizes, and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  SIE_BE_DW   = 8'hFF;
   localparam logic [7:0]  SIE_BE_W    = 8'h0F;
   localparam logic [7:0]  SIE_BE_H    = 8'h03;
   localparam logic [63:0] SIE_RST_64  = 64'h0;
   localparam logic [4:0]  SIE_RST_REG = 5'h00;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [63:0] addr;   // effective address
      logic [63:0] data;   // right-aligned store data
      logic [7:0]  be;     // byte enables of the right-aligned data
   } sie_mem_req_s;
   typedef struct packed {
      logic [4:0]  idx;
      logic [63:0] value;
   } sie_wb_s;
endpackage

// ===== src/sie_store_exec.sv
// sie_store_exec: decodes and executes a group of store instructions
// assumes register file reads arrive with the instruction, one per cycle
// Behaviour
// RULE1 - dword update store: base plus offset, writeback
// RULE2 - dword update indexed: base plus index, writeback
// RULE3 - dword indexed: zero base field reads zero
// RULE4 - update form with base zero is invalid
// RULE5 - only update forms write base register
// RULE6 - double fp stores write source unchanged
// RULE7 - indexed double fp stores, zero base reads zero
// RULE8 - fp-as-integer word stores low 32 bits raw
// RULE9 - raw word from single-produced source may be undefined
// RULE10 - single fp stores convert and write word
// RULE11 - indexed single fp stores convert, update writes back
// RULE12 - software keeps single stores' source single-format
// RULE13 - halfword stores write low 16 bits
// RULE14 - byte-reversed halfword swaps the two low bytes
// RULE15 - displacement sign-extended to 64 bits
// RULE16 - indexed fields decode at fixed positions
`timescale 1ns/1ps
module sie_store_exec
   import sie_pkg::*;
(
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   input  wire logic         ce_in,
   input  wire logic         insn_valid_in,
   input  wire logic [31:0]  insn_in,
   input  wire logic [63:0]  base_gpr_in,
   input  wire logic [63:0]  index_gpr_in,
   input  wire logic [63:0]  source_gpr_in,
   input  wire logic [63:0]  source_fpr_in,
   output logic              mem_valid_out,
   output sie_mem_req_s      mem_req_out,
   output logic              wb_valid_out,
   output sie_wb_s           wb_out,
   output logic              invalid_form_out,
   output logic              unknown_insn_out
);
   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   logic [5:0]  opc_w;
   logic [4:0]  base_fld_w;
   logic [9:0]  xo_w;
   logic [1:0]  dw_sub_w;
   logic [63:0] disp_w;
   logic [63:0] dsoff_w;
   assign opc_w      = insn_in[SIE_POS_OPC +: 6];             // RULE16
   assign base_fld_w = insn_in[SIE_POS_BAS +: 5];             // RULE16
   assign xo_w       = insn_in[SIE_POS_XO +: 10];             // RULE16
   assign dw_sub_w   = insn_in[1:0];
   assign disp_w     = {{48{insn_in[15]}}, insn_in[15:0]};    // RULE15
   assign dsoff_w    = {{48{insn_in[15]}}, insn_in[15:2], 2'b00}; // RULE1

   // single precision packing of the fpr source
   logic [31:0] sgl_w;
   sie_fp_single u_sgl (
      .dbl_in  (source_fpr_in),
      .sgl_out (sgl_w)
   );

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // indexed forms need a zero final bit; otherwise treated as unknown
   logic        hit_w, upd_w, idx_w;
   logic [63:0] data_w;
   logic [7:0]  be_w;
   always_comb begin
      hit_w  = 1'b1;
      upd_w  = 1'b0;
      idx_w  = 1'b0;
      data_w = SIE_RST_64;
      be_w   = SIE_BE_DW;
      unique case (opc_w)
         SIE_OP_DWORD: begin
            data_w = source_gpr_in;
            if (dw_sub_w == SIE_DWSUB_UPD) upd_w = 1'b1;        // RULE1
            else if (dw_sub_w != SIE_DWSUB_PLAIN) hit_w = 1'b0;
         end
         SIE_OP_STFD, SIE_OP_STFDU: begin
            data_w = source_fpr_in;                              // RULE6
            upd_w  = (opc_w == SIE_OP_STFDU);
         end
         SIE_OP_STFS, SIE_OP_STFSU: begin
            data_w = {32'h0, sgl_w};                             // RULE10
            be_w   = SIE_BE_W;
            upd_w  = (opc_w == SIE_OP_STFSU);
         end
         SIE_OP_STH, SIE_OP_STHU: begin
            data_w = {48'h0, source_gpr_in[15:0]};               // RULE13
            be_w   = SIE_BE_H;
            upd_w  = (opc_w == SIE_OP_STHU);
         end
         SIE_OP_EXT: begin
            idx_w = 1'b1;
            hit_w = ~insn_in[0];                                 // RULE16
            unique case (xo_w)
               SIE_XO_STDX:   data_w = source_gpr_in;            // RULE3
               SIE_XO_STDUX: begin
                  data_w = source_gpr_in;                        // RULE2
                  upd_w  = 1'b1;
               end
               SIE_XO_STFDX:  data_w = source_fpr_in;            // RULE7
               SIE_XO_STFDUX: begin
                  data_w = source_fpr_in;                        // RULE7
                  upd_w  = 1'b1;
               end
               SIE_XO_STFSX: begin
                  data_w = {32'h0, sgl_w};                       // RULE11
                  be_w   = SIE_BE_W;
               end
               SIE_XO_STFSUX: begin
                  data_w = {32'h0, sgl_w};                       // RULE11
                  be_w   = SIE_BE_W;
                  upd_w  = 1'b1;
               end
               SIE_XO_STFIWX: begin
                  // raw copy: a single-produced source gives an undefined word
                  data_w = {32'h0, source_fpr_in[31:0]};         // RULE8 RULE9
                  be_w   = SIE_BE_W;
               end
               SIE_XO_STHBRX: begin
                  data_w = {48'h0, source_gpr_in[7:0], source_gpr_in[15:8]}; // RULE14
                  be_w   = SIE_BE_H;
               end
               default: hit_w = 1'b0;
            endcase
         end
         default: hit_w = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // effective address
   // ----------------------------------------------------------------
   // base field zero reads as zero for every non-update form
   logic [63:0] base_val_w, offs_w, eff_addr_w;
   logic        bad_form_w;
   assign base_val_w = (base_fld_w == 5'h00 && !upd_w) ? SIE_RST_64 : base_gpr_in; // RULE3 RULE7
   assign offs_w     = idx_w ? index_gpr_in : (opc_w == SIE_OP_DWORD ? dsoff_w : disp_w);
   assign eff_addr_w = base_val_w + offs_w;                      // RULE2 RULE15
   assign bad_form_w = upd_w && (base_fld_w == 5'h00);           // RULE4

   logic go_w;
   assign go_w = ce_in && insn_valid_in;

   // ----------------------------------------------------------------
   // memory request
   // ----------------------------------------------------------------
   // the invalid form still suppresses the store; nothing partial leaks out
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mem_valid_out <= 1'b0;
         mem_req_out   <= '0;
      end else if (ce_in) begin
         mem_valid_out <= go_w && hit_w && !bad_form_w;
         mem_req_out   <= '{addr: eff_addr_w, data: data_w, be: be_w};
      end
   end

   // ----------------------------------------------------------------
   // base register writeback
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wb_valid_out <= 1'b0;
         wb_out       <= '{idx: SIE_RST_REG, value: SIE_RST_64};
      end else if (ce_in) begin
         wb_valid_out <= go_w && hit_w && upd_w && !bad_form_w;  // RULE5 RULE4
         wb_out       <= '{idx: base_fld_w, value: eff_addr_w};  // RULE5
      end
   end

   // ----------------------------------------------------------------
   // error flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         invalid_form_out <= 1'b0;
         unknown_insn_out <= 1'b0;
      end else if (ce_in) begin
         invalid_form_out <= go_w && hit_w && bad_form_w;        // RULE4
         unknown_insn_out <= go_w && !hit_w;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   wb_needs_store_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wb_valid_out |-> mem_valid_out && mem_req_out.addr == wb_out.value) // RULE5
      else $error("writeback without matching store");
   wb_nonzero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wb_valid_out |-> wb_out.idx != 5'h00)                              // RULE4
      else $error("writeback to base zero");
   bad_no_store_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      invalid_form_out |-> !mem_valid_out && !wb_valid_out)              // RULE4
      else $error("invalid form performed access");
   dw_update_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && insn_valid_in && opc_w == SIE_OP_DWORD && dw_sub_w == SIE_DWSUB_UPD
       && base_fld_w != 5'h00) |=> wb_valid_out && mem_req_out.be == SIE_BE_DW) // RULE1
      else $error("dword update missed writeback");
   dx_no_wb_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && insn_valid_in && opc_w == SIE_OP_EXT && xo_w == SIE_XO_STDX && !insn_in[0])
      |=> mem_valid_out && !wb_valid_out)                                 // RULE3
      else $error("dword indexed misbehaved");
   dux_addr_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && insn_valid_in && opc_w == SIE_OP_EXT && xo_w == SIE_XO_STDUX
       && base_fld_w != 5'h00 && !insn_in[0])
      |=> wb_valid_out && wb_out.value == $past(base_gpr_in) + $past(index_gpr_in)) // RULE2
      else $error("dword update indexed address wrong");
   hbr_swap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && insn_valid_in && opc_w == SIE_OP_EXT && xo_w == SIE_XO_STHBRX && !insn_in[0])
      |=> mem_req_out.data[15:0] == {$past(source_gpr_in[7:0]), $past(source_gpr_in[15:8])}) // RULE14
      else $error("halfword reverse wrong");
   fiw_raw_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && insn_valid_in && opc_w == SIE_OP_EXT && xo_w == SIE_XO_STFIWX && !insn_in[0])
      |=> mem_req_out.data[31:0] == $past(source_fpr_in[31:0]) && mem_req_out.be == SIE_BE_W) // RULE8
      else $error("fp as integer word not raw");
   freeze_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !ce_in |=> $stable(mem_valid_out) && $stable(wb_valid_out))
      else $error("state moved while disabled");
endmodule // sie_store_exec

// ===== tb/sie_mem_model.sv
// sie_mem_model: data memory side of the store executor, counts writes
// assumes one write per enabled mem_valid cycle and no back-pressure toward the core
`timescale 1ns/1ps
module sie_mem_model
   import sie_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         ce_in,
   input  wire logic         wr_in,
   input  wire sie_mem_req_s req_in,
   output int                n_writes_out
);
   // ----------------------------------------------------------------
   // write counter
   // ----------------------------------------------------------------
   // the memory never stalls, since the executor has no ready input
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         n_writes_out <= 0;
      // a request held through a frozen spell is one write, taken at an enabled edge
      end else if (ce_in && wr_in && req_in.be != 8'h00) begin
         n_writes_out <= n_writes_out + 1;
      end
   end
endmodule // sie_mem_model

// ===== tb/testbench.sv
// testbench: self-checking bench for the store instruction executor
// assumes one instruction per cycle and answers exactly one cycle later
`timescale 1ns/1ps
module testbench;
   import sie_pkg::*;
   logic         ref_clk_in, rst_in, ce_in, insn_valid_in;
   logic [31:0]  insn_in;
   logic [63:0]  base_gpr_in, index_gpr_in, source_gpr_in, source_fpr_in;
   logic         mem_valid_out, wb_valid_out, invalid_form_out, unknown_insn_out;
   sie_mem_req_s mem_req_out;
   sie_wb_s      wb_out;
   int           n_fail, n_checks, exp_writes, n_writes;
   sie_store_exec uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .insn_valid_in(insn_valid_in), .insn_in(insn_in), .base_gpr_in(base_gpr_in),
      .index_gpr_in(index_gpr_in), .source_gpr_in(source_gpr_in), .source_fpr_in(source_fpr_in),
      .mem_valid_out(mem_valid_out), .mem_req_out(mem_req_out), .wb_valid_out(wb_valid_out),
      .wb_out(wb_out), .invalid_form_out(invalid_form_out), .unknown_insn_out(unknown_insn_out));
   sie_mem_model mem (.clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .wr_in(mem_valid_out),
      .req_in(mem_req_out), .n_writes_out(n_writes));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // only enabled bytes are compared, the rest of the lane is don't-care
   function automatic logic [63:0] msk(input logic [7:0] be);
      for (int k = 0; k < 8; k++) msk[k*8 +: 8] = {8{be[k]}};
   endfunction
   function automatic logic [31:0] ed(input logic [5:0] op, input logic [4:0] a, input logic [15:0] d);
      return {op, 5'h03, a, d};
   endfunction
   function automatic logic [31:0] ex(input logic [9:0] xo, input logic [4:0] a);
      return {SIE_OP_EXT, 5'h03, a, 5'h04, xo, 1'b0};
   endfunction
   // drive one instruction, then judge the answer one edge later
   task automatic step(input logic [31:0] i, input logic [63:0] a, input logic [63:0] d,
                       input logic [7:0] be, input logic mv, input logic wv, input logic inv,
                       input logic unk);
      insn_in = i;
      insn_valid_in = 1'b1;
      @(negedge ref_clk_in);
      chk("mem_valid", 64'(mv), 64'(mem_valid_out));
      chk("wb_valid", 64'(wv), 64'(wb_valid_out));
      chk("invalid_form", 64'(inv), 64'(invalid_form_out));
      chk("unknown_insn", 64'(unk), 64'(unknown_insn_out));
      if (mv) begin
         exp_writes++;
         chk("addr", a, mem_req_out.addr);
         chk("be", 64'(be), 64'(mem_req_out.be));
         chk("data", d & msk(be), mem_req_out.data & msk(be));
      end
      if (wv) begin
         chk("wb_idx", 64'(i[20:16]), 64'(wb_out.idx));
         chk("wb_value", a, wb_out.value);
      end
   endtask
   // a store pulse must not linger past its one cycle
   task automatic idle();
      insn_valid_in = 1'b0;
      @(negedge ref_clk_in);
      chk("mem_valid_idle", 64'h0, 64'(mem_valid_out));
   endtask
   // ----------------------------------------------------------------
   // scenarios, base 0x1000, index 0x230, all back to back
   // ----------------------------------------------------------------
   task automatic t_dword();
      step({SIE_OP_DWORD, 5'h03, 5'h05, 14'h3FFC, SIE_DWSUB_UPD}, 64'hFF0, source_gpr_in, SIE_BE_DW, 1, 1, 0, 0);
      step(ex(SIE_XO_STDUX, 5'h05), 64'h1230, source_gpr_in, SIE_BE_DW, 1, 1, 0, 0);
      step(ex(SIE_XO_STDX, 5'h00), 64'h230, source_gpr_in, SIE_BE_DW, 1, 0, 0, 0);
      step({SIE_OP_DWORD, 5'h03, 5'h05, 14'h0004, SIE_DWSUB_PLAIN}, 64'h1010, source_gpr_in, SIE_BE_DW, 1, 0, 0, 0);
      idle();
   endtask
   task automatic t_fp_double();
      step(ed(SIE_OP_STFD, 5'h05, 16'h0008), 64'h1008, source_fpr_in, SIE_BE_DW, 1, 0, 0, 0);
      step(ed(SIE_OP_STFDU, 5'h05, 16'h8000), 64'hFFFF_FFFF_FFFF_9000, source_fpr_in, SIE_BE_DW, 1, 1, 0, 0);
      step(ex(SIE_XO_STFDX, 5'h00), 64'h230, source_fpr_in, SIE_BE_DW, 1, 0, 0, 0);
      step(ex(SIE_XO_STFDUX, 5'h05), 64'h1230, source_fpr_in, SIE_BE_DW, 1, 1, 0, 0);
      idle();
   endtask
   // fpr holds -2.5, already single-representable, single image C0200000
   task automatic t_fp_word();
      source_fpr_in = 64'h4000_0000_8765_4321;
      step(ex(SIE_XO_STFIWX, 5'h05), 64'h1230, 64'h8765_4321, SIE_BE_W, 1, 0, 0, 0);
      source_fpr_in = 64'hC004_0000_0000_0000;
      step(ed(SIE_OP_STFS, 5'h00, 16'hFFFC), 64'hFFFF_FFFF_FFFF_FFFC, 64'hC020_0000, SIE_BE_W, 1, 0, 0, 0);
      step(ed(SIE_OP_STFSU, 5'h05, 16'h0004), 64'h1004, 64'hC020_0000, SIE_BE_W, 1, 1, 0, 0);
      step(ex(SIE_XO_STFSX, 5'h05), 64'h1230, 64'hC020_0000, SIE_BE_W, 1, 0, 0, 0);
      step(ex(SIE_XO_STFSUX, 5'h05), 64'h1230, 64'hC020_0000, SIE_BE_W, 1, 1, 0, 0);
      // largest exponent below the normal range: 2 to the -127 becomes a single denormal
      source_fpr_in = 64'h3800_0000_0000_0000;
      step(ex(SIE_XO_STFSX, 5'h05), 64'h1230, 64'h0040_0000, SIE_BE_W, 1, 0, 0, 0);
      source_fpr_in = 64'hC004_0000_0000_0000;
      idle();
   endtask
   task automatic t_half();
      step(ed(SIE_OP_STH, 5'h00, 16'h0002), 64'h2, 64'h7788, SIE_BE_H, 1, 0, 0, 0);
      step(ed(SIE_OP_STHU, 5'h05, 16'hFFFE), 64'hFFE, 64'h7788, SIE_BE_H, 1, 1, 0, 0);
      step(ex(SIE_XO_STHBRX, 5'h05), 64'h1230, 64'h8877, SIE_BE_H, 1, 0, 0, 0);
      idle();
   endtask
   task automatic t_refuse();
      step({SIE_OP_DWORD, 5'h03, 5'h00, 14'h0004, SIE_DWSUB_UPD}, 64'h0, 64'h0, 8'h00, 0, 0, 1, 0);
      step(ed(SIE_OP_STHU, 5'h00, 16'h0002), 64'h0, 64'h0, 8'h00, 0, 0, 1, 0);
      step(ex(SIE_XO_STFSUX, 5'h00), 64'h0, 64'h0, 8'h00, 0, 0, 1, 0);
      step(ex(SIE_XO_STDX, 5'h05) | 32'h1, 64'h0, 64'h0, 8'h00, 0, 0, 0, 1);
      step(ex(10'h000, 5'h05), 64'h0, 64'h0, 8'h00, 0, 0, 0, 1);
      idle();
   endtask
   // enable low: the last answer must stand and a waiting instruction must not be taken
   task automatic t_freeze();
      step(ed(SIE_OP_STHU, 5'h05, 16'h0002), 64'h1002, 64'h7788, SIE_BE_H, 1, 1, 0, 0);
      ce_in = 1'b0;
      insn_in = ex(SIE_XO_STDX, 5'h05);
      repeat (2) @(negedge ref_clk_in);
      chk("mem_valid_held", 64'h1, 64'(mem_valid_out));
      chk("wb_valid_held", 64'h1, 64'(wb_valid_out));
      chk("addr_held", 64'h1002, mem_req_out.addr);
      ce_in = 1'b1;
      idle();
   endtask
   // ----------------------------------------------------------------
   // clock, run and verdict
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // a full run is under 60 cycles, so 2000 means a hang
   initial begin
      repeat (2000) @(posedge ref_clk_in);
      n_fail++;
      give_verdict();
   end
   initial begin
      {rst_in, ce_in, insn_valid_in, insn_in} = {1'b1, 1'b1, 1'b0, 32'h0};
      {base_gpr_in, index_gpr_in} = {64'h1000, 64'h230};
      {source_gpr_in, source_fpr_in} = {64'h1122_3344_5566_7788, 64'hC004_0000_0000_0000};
      repeat (6) @(negedge ref_clk_in);
      rst_in = 1'b0;
      chk("mem_valid_rst", 64'h0, 64'(mem_valid_out));
      t_dword();
      t_fp_double();
      t_fp_word();
      t_half();
      t_refuse();
      t_freeze();
      chk("model_writes", 64'(exp_writes), 64'(n_writes));
      give_verdict();
   end
endmodule // testbench
